// ==== inc/scp_pkg.sv ====
// Register map, field positions and reset values of the clock control block
package scp_pkg;
   localparam int unsigned SCP_AW = 16;
   localparam int unsigned SCP_FTW_W = 48;
   localparam logic [15:0] SCP_ADR_UPDATE = 16'h0005;
   localparam logic [15:0] SCP_ADR_RSVD_SLOT = 16'h0021;
   localparam logic [15:0] SCP_ADR_PLL_PAR = 16'h0022;
   localparam logic [15:0] SCP_ADR_PFD_DIV = 16'h0023;
   localparam logic [15:0] SCP_ADR_LOOP_CTL = 16'h0100;
   localparam logic [15:0] SCP_ADR_RDIV_LO = 16'h0101;
   localparam logic [15:0] SCP_ADR_RDIV_HI = 16'h0102;
   localparam logic [15:0] SCP_ADR_RDIV_CTL = 16'h0103;
   localparam logic [15:0] SCP_ADR_EST_FIRST = 16'h0115;
   localparam logic [15:0] SCP_ADR_EST_LAST = 16'h011A;
   // Writable bits per register; all others are reserved
   localparam logic [7:0] SCP_MSK_PLL_PAR = 8'h8F;
   localparam logic [7:0] SCP_MSK_PFD_DIV = 8'h0F;
   localparam logic [7:0] SCP_MSK_LOOP_CTL = 8'h3B;
   localparam logic [7:0] SCP_MSK_RDIV_CTL = 8'h81;
   // Field positions
   localparam int unsigned SCP_B_VCO_HIGH = 2;
   localparam int unsigned SCP_B_REF_DBL = 3;
   localparam int unsigned SCP_B_VCO_AUTO = 7;
   localparam int unsigned SCP_B_CLOSE = 0;
   localparam int unsigned SCP_B_POL = 1;
   localparam int unsigned SCP_B_SLEW = 3;
   localparam int unsigned SCP_B_EST_DIS = 4;
   localparam int unsigned SCP_B_TONE = 5;
   localparam int unsigned SCP_B_PRESC = 0;
   localparam int unsigned SCP_B_FALL = 7;
   localparam int unsigned SCP_B_UPDATE = 0;
   // Reset values
   localparam logic [7:0] SCP_RST_BYTE = 8'h00;
   localparam logic [5:0] SCP_RST_CNT = 6'h00;
   // Charge pump current in microamps per code
   localparam logic [8:0] SCP_CP_UA_00 = 9'd250;
   localparam logic [8:0] SCP_CP_UA_01 = 9'd375;
   localparam logic [8:0] SCP_CP_UA_10 = 9'd0;
   localparam logic [8:0] SCP_CP_UA_11 = 9'd125;
   localparam logic [1:0] SCP_CP_OFF = 2'b10;
   localparam int unsigned SCP_PFD_MUL = 4;
endpackage

// ==== rtl/scp_ref_divider.sv ====
// Reference edge select, divide-by-two prescaler and divide-by-(R+1) counter
`timescale 1ns/10ps
module scp_ref_divider #(
   parameter int unsigned RW = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic ref_lvl_i,
   input wire logic fall_edge_i,
   input wire logic presc_en_i,
   input wire logic [RW-1:0] ratio_i,
   output logic div_tick_o
);
   logic ref_d_r;
   logic presc_r;
   logic [RW-1:0] cnt_r;
   logic ref_x;
   logic edge_w;
   logic count_w;

   assign ref_x = ref_lvl_i ^ fall_edge_i; // RULE21
   assign edge_w = ref_x & ~ref_d_r;
   assign count_w = edge_w & (~presc_en_i | presc_r); // RULE20

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_d_r <= 1'b0;
         presc_r <= 1'b0;
      end else if (ce_i) begin
         ref_d_r <= ref_x;
         if (edge_w) begin
            presc_r <= presc_en_i ? ~presc_r : 1'b0;
         end
      end
   end

   // Zero ratio gives one tick per counted edge
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= '0;
         div_tick_o <= 1'b0;
      end else if (ce_i) begin
         div_tick_o <= 1'b0;
         if (count_w) begin
            if (cnt_r >= ratio_i) begin // RULE17
               cnt_r <= '0;
               div_tick_o <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule

// ==== rtl/scp_clock_ctrl.sv ====
// System clock PLL and digital loop control registers
`timescale 1ns/10ps
// Overview of operation
// RULE1: Pump current code 00=250uA, 01=375uA, 10=off, 11=125uA.
// RULE2: Band bit 0 picks low band, 1 picks high band.
// RULE3: With auto band enabled, hardware chooses the band bit itself.
// RULE4: Software should use auto band between 810 and 900 MHz.
// RULE5: Doubler enable bit places a doubler before the system clock PLL.
// RULE6: Sampling clock is system clock divided by four times field.
// RULE7: Loop phase detector runs at half the sampling clock rate.
// RULE8: Loop-closure bit set closes the loop, cleared opens it.
// RULE9: Closed loop with estimator not disabled uses the estimator.
// RULE10: Software pulses integrator and filter resets before reclosing.
// RULE11: Polarity bit inverts the sign of the loop response.
// RULE12: Slew limiter bit bounds tuning word change per step.
// RULE13: Estimator result readable in six bytes.
// RULE14: Estimator may be disabled once open-loop word is programmed.
// RULE15: Single-tone bit outputs open-loop word as synthesizer word.
// RULE16: Software keeps single-tone cleared while loop is closed.
// RULE17: Reference divider ratio is value plus one, zero gives one.
// RULE18: Reference divider low byte sits at the lower address.
// RULE19: Software sets prescaler above 65536 or reference above 400 MHz.
// RULE20: Prescaler bit adds a divide-by-two before reference divider.
// RULE21: Edge-select bit inverts reference before the divider.
// RULE22: Writing one to update bit moves buffered values to active.
// RULE23: Reserved bits read zero and ignore writes.
module scp_clock_ctrl #(
   parameter int unsigned FTW_W = 48,
   parameter int unsigned RDIV_W = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [scp_pkg::SCP_AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic io_update_i,
   input wire logic band_cal_high_i,
   input wire logic ref_lvl_i,
   input wire logic signed [15:0] phase_err_i,
   input wire logic [FTW_W-1:0] loop_ftw_i,
   input wire logic [FTW_W-1:0] open_loop_tuning_word_i,
   input wire logic [FTW_W-1:0] slew_step_i,
   input wire logic [FTW_W-1:0] est_word_i,
   output logic [7:0] reg_rdata_o,
   output logic [8:0] cp_current_ua_o,
   output logic cp_enable_o,
   output logic vco_band_high_o,
   output logic ref_doubler_en_o,
   output logic sample_tick_o,
   output logic pd_tick_o,
   output logic loop_closed_o,
   output logic estimator_active_o,
   output logic signed [15:0] loop_err_o,
   output logic single_tone_o,
   output logic [FTW_W-1:0] dds_ftw_o,
   output logic ref_div_tick_o
);
   import scp_pkg::*;

   logic [7:0] buf_pll_r, act_pll_r;
   logic [7:0] buf_pfd_r, act_pfd_r;
   logic [7:0] buf_ctl_r, act_ctl_r;
   logic [7:0] buf_rlo_r, act_rlo_r;
   logic [7:0] buf_rhi_r, act_rhi_r;
   logic [7:0] buf_rct_r, act_rct_r;
   logic update_w;
   logic [5:0] pfd_cnt_r;
   logic [5:0] pfd_top_w;
   logic pd_phase_r;
   logic [FTW_W-1:0] target_w;
   logic [FTW_W-1:0] ftw_nxt;
   logic div_tick_w;

   function automatic logic [7:0] est_byte(input logic [15:0] a, input logic [FTW_W-1:0] w);
      logic [15:0] idx;
      idx = a - SCP_ADR_EST_FIRST;
      est_byte = w[idx[2:0]*8 +: 8];
   endfunction

   function automatic logic [8:0] cp_ua(input logic [1:0] code);
      cp_ua = SCP_CP_UA_00;
      case (code)
         2'b01: cp_ua = SCP_CP_UA_01;
         2'b10: cp_ua = SCP_CP_UA_10;
         2'b11: cp_ua = SCP_CP_UA_11;
         default: cp_ua = SCP_CP_UA_00;
      endcase
   endfunction

   // Self-clearing update bit: never stored, acts in the write cycle
   assign update_w = io_update_i |
      (reg_wr_i && reg_addr_i == SCP_ADR_UPDATE && reg_wdata_i[SCP_B_UPDATE]); // RULE22

   // Buffered side of the map, writes masked to defined bits
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buf_pll_r <= SCP_RST_BYTE;
         buf_pfd_r <= SCP_RST_BYTE;
         buf_ctl_r <= SCP_RST_BYTE;
         buf_rlo_r <= SCP_RST_BYTE;
         buf_rhi_r <= SCP_RST_BYTE;
         buf_rct_r <= SCP_RST_BYTE;
      end else if (ce_i && reg_wr_i) begin
         if (reg_addr_i == SCP_ADR_PLL_PAR) begin
            buf_pll_r <= reg_wdata_i & SCP_MSK_PLL_PAR; // RULE23
         end else if (reg_addr_i == SCP_ADR_PFD_DIV) begin
            buf_pfd_r <= reg_wdata_i & SCP_MSK_PFD_DIV; // RULE23
         end else if (reg_addr_i == SCP_ADR_LOOP_CTL) begin
            buf_ctl_r <= reg_wdata_i & SCP_MSK_LOOP_CTL; // RULE23
         end else if (reg_addr_i == SCP_ADR_RDIV_LO) begin
            buf_rlo_r <= reg_wdata_i; // RULE18
         end else if (reg_addr_i == SCP_ADR_RDIV_HI) begin
            buf_rhi_r <= reg_wdata_i; // RULE18
         end else if (reg_addr_i == SCP_ADR_RDIV_CTL) begin
            buf_rct_r <= reg_wdata_i & SCP_MSK_RDIV_CTL; // RULE23
         end
      end
   end

   // Active copy; a write in the update cycle lands next update
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         act_pll_r <= SCP_RST_BYTE;
         act_pfd_r <= SCP_RST_BYTE;
         act_ctl_r <= SCP_RST_BYTE;
         act_rlo_r <= SCP_RST_BYTE;
         act_rhi_r <= SCP_RST_BYTE;
         act_rct_r <= SCP_RST_BYTE;
      end else if (ce_i && update_w) begin // RULE22
         act_pll_r <= buf_pll_r;
         act_pfd_r <= buf_pfd_r;
         act_ctl_r <= buf_ctl_r;
         act_rlo_r <= buf_rlo_r;
         act_rhi_r <= buf_rhi_r;
         act_rct_r <= buf_rct_r;
      end
   end

   // Read port returns active values; data valid the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= SCP_RST_BYTE;
      end else if (ce_i && reg_rd_i) begin
         if (reg_addr_i == SCP_ADR_PLL_PAR) begin
            reg_rdata_o <= {act_pll_r[7:3], vco_band_high_o, act_pll_r[1:0]}; // RULE3
         end else if (reg_addr_i == SCP_ADR_PFD_DIV) begin
            reg_rdata_o <= act_pfd_r;
         end else if (reg_addr_i == SCP_ADR_LOOP_CTL) begin
            reg_rdata_o <= act_ctl_r;
         end else if (reg_addr_i == SCP_ADR_RDIV_LO) begin
            reg_rdata_o <= act_rlo_r;
         end else if (reg_addr_i == SCP_ADR_RDIV_HI) begin
            reg_rdata_o <= act_rhi_r;
         end else if (reg_addr_i == SCP_ADR_RDIV_CTL) begin
            reg_rdata_o <= act_rct_r;
         end else if (reg_addr_i >= SCP_ADR_EST_FIRST && reg_addr_i <= SCP_ADR_EST_LAST) begin
            reg_rdata_o <= est_byte(reg_addr_i, est_word_i); // RULE13
         end else begin
            reg_rdata_o <= SCP_RST_BYTE; // RULE23
         end
      end
   end

   // Analog PLL settings
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cp_current_ua_o <= SCP_CP_UA_00;
         cp_enable_o <= 1'b1;
         vco_band_high_o <= 1'b0;
         ref_doubler_en_o <= 1'b0;
      end else if (ce_i) begin
         cp_current_ua_o <= cp_ua(act_pll_r[1:0]); // RULE1
         cp_enable_o <= act_pll_r[1:0] != SCP_CP_OFF; // RULE1
         // Auto mode follows band calibration, not the written bit
         vco_band_high_o <= act_pll_r[SCP_B_VCO_AUTO] ? band_cal_high_i
                                                      : act_pll_r[SCP_B_VCO_HIGH]; // RULE2 RULE3
         ref_doubler_en_o <= act_pll_r[SCP_B_REF_DBL]; // RULE5
      end
   end

   // Field of zero stops the sampling clock instead of dividing by zero
   assign pfd_top_w = 6'(SCP_PFD_MUL * act_pfd_r[3:0]) - 6'd1; // RULE6

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pfd_cnt_r <= SCP_RST_CNT;
         sample_tick_o <= 1'b0;
         pd_phase_r <= 1'b0;
         pd_tick_o <= 1'b0;
      end else if (ce_i) begin
         sample_tick_o <= 1'b0;
         pd_tick_o <= 1'b0;
         if (act_pfd_r[3:0] == 4'h0) begin
            pfd_cnt_r <= SCP_RST_CNT;
         end else if (pfd_cnt_r >= pfd_top_w) begin
            pfd_cnt_r <= SCP_RST_CNT;
            sample_tick_o <= 1'b1; // RULE6
            pd_phase_r <= ~pd_phase_r;
            pd_tick_o <= pd_phase_r; // RULE7
         end else begin
            pfd_cnt_r <= pfd_cnt_r + 6'd1;
         end
      end
   end

   // Digital loop controls
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loop_closed_o <= 1'b0;
         estimator_active_o <= 1'b0;
         loop_err_o <= '0;
         single_tone_o <= 1'b0;
      end else if (ce_i) begin
         loop_closed_o <= act_ctl_r[SCP_B_CLOSE]; // RULE8
         estimator_active_o <= act_ctl_r[SCP_B_CLOSE] & ~act_ctl_r[SCP_B_EST_DIS]; // RULE9 RULE14
         loop_err_o <= act_ctl_r[SCP_B_POL] ? -phase_err_i : phase_err_i; // RULE11
         single_tone_o <= act_ctl_r[SCP_B_TONE]; // RULE15
      end
   end

   // Tone wins over loop word; closing the loop with tone set is misuse
   assign target_w = act_ctl_r[SCP_B_TONE] ? open_loop_tuning_word_i : loop_ftw_i; // RULE15

   always_comb begin
      ftw_nxt = target_w;
      if (act_ctl_r[SCP_B_SLEW]) begin
         if (target_w > dds_ftw_o && target_w - dds_ftw_o > slew_step_i) begin
            ftw_nxt = dds_ftw_o + slew_step_i; // RULE12
         end else if (dds_ftw_o > target_w && dds_ftw_o - target_w > slew_step_i) begin
            ftw_nxt = dds_ftw_o - slew_step_i; // RULE12
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dds_ftw_o <= '0;
      end else if (ce_i) begin
         dds_ftw_o <= ftw_nxt;
      end
   end

   scp_ref_divider #(
      .RW(RDIV_W)
   ) u_rdiv (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .ref_lvl_i(ref_lvl_i),
      .fall_edge_i(act_rct_r[SCP_B_FALL]),
      .presc_en_i(act_rct_r[SCP_B_PRESC]),
      .ratio_i({act_rhi_r, act_rlo_r}),
      .div_tick_o(div_tick_w)
   );

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_div_tick_o <= 1'b0;
      end else if (ce_i) begin
         ref_div_tick_o <= div_tick_w;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_update;
      ce_i && update_w;
   endsequence
   sequence s_settle;
      ce_i [*2];
   endsequence

   a_cp_off_code: assert property (s_update ##1 (act_pll_r[1:0] == SCP_CP_OFF) ##0 s_settle // RULE1
      |-> !cp_enable_o && cp_current_ua_o == SCP_CP_UA_10)
      else $error("Pump not off for code 10");
   a_band_auto_follow: assert property ((ce_i && act_pll_r[SCP_B_VCO_AUTO]) // RULE3
      |=> vco_band_high_o == $past(band_cal_high_i))
      else $error("Auto band ignores calibration");
   a_update_copy: assert property (s_update |=> act_ctl_r == $past(buf_ctl_r)) // RULE22
      else $error("Update did not transfer buffer");
   a_pd_half_rate: assert property ((ce_i && sample_tick_o && pd_tick_o) // RULE7
      |-> !$past(pd_tick_o))
      else $error("Phase detector tick too fast");
   a_est_active: assert property (ce_i |=> estimator_active_o == // RULE9
      $past(act_ctl_r[SCP_B_CLOSE] & ~act_ctl_r[SCP_B_EST_DIS]))
      else $error("Estimator enable wrong");
   a_pol_invert: assert property ((ce_i && act_ctl_r[SCP_B_POL]) // RULE11
      |=> loop_err_o == -$past(phase_err_i))
      else $error("Polarity not applied");
   a_slew_bound: assert property ((ce_i && act_ctl_r[SCP_B_SLEW]) // RULE12
      |=> (dds_ftw_o >= $past(dds_ftw_o) ? dds_ftw_o - $past(dds_ftw_o)
                                          : $past(dds_ftw_o) - dds_ftw_o) <= $past(slew_step_i))
      else $error("Slew step exceeded");
   a_tone_word: assert property ((ce_i && act_ctl_r[SCP_B_TONE] && !act_ctl_r[SCP_B_SLEW]) // RULE15
      |=> dds_ftw_o == $past(open_loop_tuning_word_i))
      else $error("Tone word not used");
   a_rsvd_zero: assert property ((ce_i && reg_rd_i && reg_addr_i == SCP_ADR_LOOP_CTL) // RULE23
      |=> (reg_rdata_o & ~SCP_MSK_LOOP_CTL) == 8'h00)
      else $error("Reserved bits read nonzero");
   a_sample_gap: assert property ((ce_i && sample_tick_o && act_pfd_r[3:0] != 4'h0 && // RULE6
      $stable(act_pfd_r)) |-> !$past(sample_tick_o) && !$past(sample_tick_o, 3))
      else $error("Sampling tick spacing wrong");
endmodule

// ==== test/system_clock_source_pll_and_dpll_control_regs_bench.sv ====
// Self-checking bench for the clock control register block
`timescale 1ns/10ps
module system_clock_source_pll_and_dpll_control_regs_bench;
   import scp_pkg::*;
   logic sys_clk_i;
   logic rst_b_i;
   logic ce_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [15:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic io_update_i;
   logic band_cal_high_i;
   logic ref_lvl_i;
   logic signed [15:0] phase_err_i;
   logic [47:0] loop_ftw_i;
   logic [47:0] open_loop_tuning_word_i;
   logic [47:0] slew_step_i;
   logic [47:0] est_word_i;
   logic [7:0] reg_rdata_o;
   logic [8:0] cp_current_ua_o;
   logic cp_enable_o;
   logic vco_band_high_o;
   logic ref_doubler_en_o;
   logic sample_tick_o;
   logic pd_tick_o;
   logic loop_closed_o;
   logic estimator_active_o;
   logic signed [15:0] loop_err_o;
   logic single_tone_o;
   logic [47:0] dds_ftw_o;
   logic ref_div_tick_o;
   int n_mismatch;
   int samples_checked;
   int g;
   logic [8:0] ua_tab [4];

   scp_clock_ctrl u_scp_clock_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .io_update_i(io_update_i),
      .band_cal_high_i(band_cal_high_i), .ref_lvl_i(ref_lvl_i), .phase_err_i(phase_err_i),
      .loop_ftw_i(loop_ftw_i), .open_loop_tuning_word_i(open_loop_tuning_word_i),
      .slew_step_i(slew_step_i), .est_word_i(est_word_i), .reg_rdata_o(reg_rdata_o),
      .cp_current_ua_o(cp_current_ua_o), .cp_enable_o(cp_enable_o),
      .vco_band_high_o(vco_band_high_o), .ref_doubler_en_o(ref_doubler_en_o),
      .sample_tick_o(sample_tick_o), .pd_tick_o(pd_tick_o), .loop_closed_o(loop_closed_o),
      .estimator_active_o(estimator_active_o), .loop_err_o(loop_err_o),
      .single_tone_o(single_tone_o), .dds_ftw_o(dds_ftw_o), .ref_div_tick_o(ref_div_tick_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      chk(reg_rdata_o, exp);
   endtask

   // Update through the self-clearing register bit
   task automatic upd();
      wr(SCP_ADR_UPDATE, 8'h01);
      repeat (3) @(posedge sys_clk_i);
      #1;
   endtask

   // Update through the pin, so both paths are exercised
   task automatic upd_pin();
      @(posedge sys_clk_i);
      io_update_i <= 1'b1;
      @(posedge sys_clk_i);
      io_update_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1;
   endtask

   // Bounded window; a missing pulse leaves the gap at zero and fails
   task automatic tick_gap(input int which, input int span, output int gp);
      int lst;
      logic hit;
      lst = -1;
      gp = 0;
      for (int i = 0; i < span; i++) begin
         @(posedge sys_clk_i);
         ref_lvl_i <= ~ref_lvl_i;
         #1;
         hit = (which == 0) ? sample_tick_o : (which == 1) ? pd_tick_o : ref_div_tick_o;
         if (hit === 1'b1) begin
            if (lst >= 0) gp = i - lst;
            lst = i;
         end
      end
   endtask

   initial begin
      ua_tab = '{9'h0fa, 9'h177, 9'h000, 9'h07d};
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 16'h0000;
      reg_wdata_i = 8'h00;
      io_update_i = 1'b0;
      band_cal_high_i = 1'b0;
      ref_lvl_i = 1'b0;
      phase_err_i = 16'sh0005;
      loop_ftw_i = 48'h0000_0000_1000;
      open_loop_tuning_word_i = 48'h1234_5678_9abc;
      slew_step_i = 48'h0000_0000_0010;
      est_word_i = 48'ha1b2_c3d4_e5f6;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (8) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      #1;
      chk(cp_current_ua_o, 9'h0fa);
      rd(SCP_ADR_PLL_PAR, 8'h00);
      // Reserved slot and reserved bits
      wr(SCP_ADR_RSVD_SLOT, 8'hff);
      rd(SCP_ADR_RSVD_SLOT, 8'h00);
      rd(16'h0200, 8'h00);
      wr(SCP_ADR_PLL_PAR, 8'hff);
      upd();
      chk(vco_band_high_o, 1'b0);
      chk(ref_doubler_en_o, 1'b1);
      rd(SCP_ADR_PLL_PAR, 8'h8b);
      @(posedge sys_clk_i);
      band_cal_high_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk(vco_band_high_o, 1'b1);
      rd(SCP_ADR_PLL_PAR, 8'h8f);
      // Every pump code; manual band ignores the calibration input
      for (int c = 0; c < 4; c++) begin
         wr(SCP_ADR_PLL_PAR, 8'(c) | (c[0] ? 8'h04 : 8'h00));
         upd();
         chk(cp_current_ua_o, ua_tab[c]);
         chk(cp_enable_o, c != 2);
         chk(vco_band_high_o, c[0]);
         chk(ref_doubler_en_o, 1'b0);
      end
      // Buffered loop control only acts at update
      wr(SCP_ADR_LOOP_CTL, 8'h01);
      rd(SCP_ADR_LOOP_CTL, 8'h00);
      chk(loop_closed_o, 1'b0);
      upd();
      rd(SCP_ADR_UPDATE, 8'h00);
      chk(loop_closed_o, 1'b1);
      chk(estimator_active_o, 1'b1);
      chk($unsigned(loop_err_o), 16'h0005);
      wr(SCP_ADR_LOOP_CTL, 8'h13);
      upd();
      chk(estimator_active_o, 1'b0);
      chk($unsigned(loop_err_o), 16'hfffb);
      // Tone bit left clear while the loop is closed
      wr(SCP_ADR_LOOP_CTL, 8'hdf);
      upd();
      rd(SCP_ADR_LOOP_CTL, 8'h1b);
      // Loop stays open from here, so no reclose sequence is needed
      wr(SCP_ADR_LOOP_CTL, 8'h20);
      upd_pin();
      chk(loop_closed_o, 1'b0);
      chk(single_tone_o, 1'b1);
      chk(dds_ftw_o, 48'h1234_5678_9abc);
      // Slew on, tone off: word walks down by one step per cycle
      wr(SCP_ADR_LOOP_CTL, 8'h08);
      upd();
      chk(dds_ftw_o, 48'h1234_5678_9a8c);
      chk(single_tone_o, 1'b0);
      // Sampling clock divider of 2 gives 8 cycles, detector twice that
      wr(SCP_ADR_PFD_DIV, 8'hf2);
      upd();
      rd(SCP_ADR_PFD_DIV, 8'h02);
      tick_gap(0, 100, g);
      chk(g, 8);
      tick_gap(1, 100, g);
      chk(g, 16);
      // Reference toggles each cycle, one rising edge per 2 cycles
      tick_gap(2, 40, g);
      chk(g, 2);
      wr(SCP_ADR_RDIV_LO, 8'h02);
      wr(SCP_ADR_RDIV_HI, 8'h01);
      rd(SCP_ADR_RDIV_LO, 8'h00);
      upd_pin();
      rd(SCP_ADR_RDIV_LO, 8'h02);
      rd(SCP_ADR_RDIV_HI, 8'h01);
      tick_gap(2, 1200, g);
      chk(g, 518);
      wr(SCP_ADR_RDIV_CTL, 8'hff);
      upd();
      rd(SCP_ADR_RDIV_CTL, 8'h81);
      tick_gap(2, 2400, g);
      chk(g, 1036);
      // Estimator bytes, least significant first
      for (int n = 0; n < 6; n++) begin
         rd(16'(SCP_ADR_EST_FIRST + n), est_word_i[8*n +: 8]);
      end
      report_and_stop();
   end
endmodule
